// file: include/rsw_pkg.sv
// shared constants, register map and types of the reset source controller
// assumes one clock, pclk, which is also the system clock seen by the watchdog
package rsw_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200; // pclk rate
  localparam int unsigned POR_TIMEOUT_US = 100000; // supply monitor timeout, 100 ms
  localparam int unsigned POR_CYCLES = POR_TIMEOUT_US * CLK_MHZ; // cycles of the supply timeout
  localparam int unsigned MCD_TIMEOUT_US = 100; // missing clock timeout
  localparam int unsigned MCD_CYCLES = MCD_TIMEOUT_US * CLK_MHZ; // cycles of the missing clock timeout
  localparam int unsigned PIN_HOLD_CYCLES = 12; // least stay in reset after the pin lets go
  localparam int unsigned TMR_W = 25; // width of the reset and missing clock timers

  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam int unsigned APB_AW = 8; // apb address width
  localparam logic [APB_AW-1:0] OFS_RST_SRC = 8'h00; // reset source register
  localparam logic [APB_AW-1:0] OFS_WDOG = 8'h04; // watchdog control register
  localparam logic [7:0] RST_SRC_RESET = 8'h00; // reset value of the source flags

  // reset source register bit positions
  localparam int unsigned BIT_PIN = 0; // pin flag, write 1 forces a power-on reset
  localparam int unsigned BIT_POR = 1; // power-on flag, write selects the supply monitor
  localparam int unsigned BIT_MCD = 2; // missing clock flag and enable
  localparam int unsigned BIT_SW = 4; // software reset force and flag
  localparam int unsigned BIT_CMP = 5; // comparator reset enable and flag
  localparam int unsigned BIT_CNV = 6; // conversion start reset enable and flag
  localparam int unsigned NUM_FLAGS = 7; // flag bits 6..0

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  localparam int unsigned WD_CNT_W = 21; // watchdog counter width
  localparam int unsigned WD_EXP_BASE = 3; // interval is 4 to the (base + field)
  localparam int unsigned WD_KEY_BIT = 7; // must be zero for an interval write
  localparam int unsigned WD_STATUS_BIT = 4; // read position of the active status
  localparam logic [7:0] KEY_RELOAD = 8'ha5; // enable and restart
  localparam logic [7:0] KEY_DIS1 = 8'hde; // first disable key
  localparam logic [7:0] KEY_DIS2 = 8'had; // second disable key
  localparam logic [7:0] KEY_LOCK = 8'hff; // lock out disable
  localparam logic [2:0] DIS_WINDOW = 3'h4; // clocks allowed between the disable keys
  localparam logic [2:0] WD_INT_RESET = 3'h7; // interval after any reset

  // ------------------------------------------------------------
  // reset exit defaults
  // ------------------------------------------------------------
  localparam logic [7:0] PORT_RESET_VALUE = 8'hff; // port latches during reset
  localparam logic [15:0] RESET_VECTOR = 16'h0000; // first fetch address
  localparam logic CLK_SRC_INTERNAL = 1'b0; // system clock from the internal oscillator
  localparam logic [1:0] OSC_FREQ_LOWEST = 2'h0; // lowest oscillator divider setting

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, // device running
    ST_ACTIVE = 2'b01, // a reset source was seen; held while por or pin asserted
    ST_STRETCH = 2'b10, // source released, timing out
    ST_WAIT_CLK = 2'b11 // waiting for a stable clock before fetch
  } rsw_state_t;

  // cause codes equal their flag bit positions
  typedef enum logic [2:0] {
    CAUSE_PIN = 3'h0,
    CAUSE_POR = 3'h1,
    CAUSE_MCD = 3'h2,
    CAUSE_WDT = 3'h3,
    CAUSE_SW = 3'h4,
    CAUSE_CMP = 3'h5,
    CAUSE_CNV = 3'h6
  } rsw_cause_t;

  // one flag bit for a cause
  function automatic logic [NUM_FLAGS-1:0] cause_flag(input rsw_cause_t c);
    cause_flag = NUM_FLAGS'(1) << c;
  endfunction

endpackage

// file: tb/rsw_checker.sv
// concurrent checks on the ports of the reset source controller
// assumes one clock pclk and the asynchronous active-low reset presetn
`timescale 1ns/1ps
module rsw_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [rsw_pkg::APB_AW-1:0] paddr,
  input wire logic pready_r,
  input wire logic pslverr_r,
  input wire logic rst_pin_in_n,
  input wire logic rst_pin_out_r,
  input wire logic rst_pin_oe_n_r,
  input wire logic supply_monitor_enable_pin,
  input wire logic supply_above_threshold,
  input wire logic conversion_start_signal_n,
  input wire logic clock_stable,
  input wire logic sys_rst_n_r,
  input wire logic port_latch_load_r,
  input wire logic [7:0] port_latch_r,
  input wire logic [15:0] fetch_addr_r,
  input wire logic clk_src_sel_r,
  input wire logic [1:0] osc_freq_sel_r,
  input wire logic adc_trigger_r
);
  import rsw_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // twelve cycles in reset, split to keep repetitions short
  sequence s_hold;
    !sys_rst_n_r [*8] ##1 !sys_rst_n_r [*4];
  endsequence
  property p_latch;
    !sys_rst_n_r && !$past(sys_rst_n_r) |-> port_latch_load_r && port_latch_r == 8'hff;
  endproperty
  property p_exit;
    sys_rst_n_r |-> fetch_addr_r == 16'h0000 && clk_src_sel_r == 1'b0 && osc_freq_sel_r == 2'h0;
  endproperty
  property p_clk_wait;
    $rose(sys_rst_n_r) |-> $past(clock_stable);
  endproperty
  property p_pin_enter;
    sys_rst_n_r && rst_pin_oe_n_r && !rst_pin_in_n |=> !sys_rst_n_r;
  endproperty
  property p_pin_hold;
    $rose(rst_pin_in_n) && $past(rst_pin_oe_n_r) && !sys_rst_n_r |-> s_hold;
  endproperty
  property p_drive;
    !rst_pin_oe_n_r |-> !sys_rst_n_r && !rst_pin_out_r;
  endproperty
  property p_supply;
    supply_monitor_enable_pin && !supply_above_threshold && sys_rst_n_r |=> !sys_rst_n_r ##[0:2] !rst_pin_oe_n_r;
  endproperty
  property p_ready;
    psel && !penable |=> pready_r ##1 !pready_r;
  endproperty
  property p_slverr;
    psel && !penable && paddr != OFS_RST_SRC && paddr != OFS_WDOG |=> pslverr_r && pready_r;
  endproperty
  property p_adc;
    adc_trigger_r |-> !$past(conversion_start_signal_n);
  endproperty
  a_latch: assert property (p_latch) else $error("port latches not all ones in reset");
  a_exit: assert property (p_exit) else $error("exit defaults wrong");
  a_clk_wait: assert property (p_clk_wait) else $error("left reset before clock stable");
  a_pin_enter: assert property (p_pin_enter) else $error("pin low did not reset");
  a_pin_hold: assert property (p_pin_hold) else $error("left reset too soon after pin release");
  a_drive: assert property (p_drive) else $error("pin driven outside reset");
  a_supply: assert property (p_supply) else $error("supply fail did not reset with pin driven");
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  a_slverr: assert property (p_slverr) else $error("unmapped access without error");
  a_adc: assert property (p_adc) else $error("conversion trigger without start low");
endmodule // rsw_checker

// file: tb/rsw_ext_model.sv
// model of the outside reset circuitry and the system clock source
// assumes the pin has a pull-up and the device drives it through an active-low enable
`timescale 1ns/1ps
module rsw_ext_model (
  input wire logic pclk,
  input wire logic hold_low,
  input wire logic clk_run,
  input wire logic rst_pin_out_r,
  input wire logic rst_pin_oe_n_r,
  output logic rst_pin_in_n,
  output logic sysclk_tick,
  output logic clock_stable
);
  // pull-up wins unless the device or the outside circuit pulls low
  assign rst_pin_in_n = (rst_pin_oe_n_r ? 1'b1 : rst_pin_out_r) & ~hold_low;
  // clock reported stable only while it runs
  assign clock_stable = clk_run;
  initial sysclk_tick = 1'b0;
  // system clock toggles each pclk, stops when clk_run drops
  always @(posedge pclk) begin
    if (clk_run) sysclk_tick <= ~sysclk_tick;
  end
endmodule // rsw_ext_model

// file: tb/rsw_reset_ctrl_tb.sv
// self-checking bench of the reset source controller over apb
// assumes the outside model on the pin and short timeouts by parameter
`timescale 1ns/1ps
module rsw_reset_ctrl_tb;
  import rsw_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, hold_low, clk_run, drove, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_r, r;
  logic pready_r, pslverr_r, rst_pin_in_n, rst_pin_out_r, rst_pin_oe_n_r, sysclk_tick, clock_stable;
  logic supply_monitor_enable_pin, supply_above_threshold, comparator_below, conversion_start_signal_n;
  logic sys_rst_n_r, port_latch_load_r, fetch_en_r, clk_src_sel_r, adc_trigger_r;
  logic [7:0] port_latch_r;
  logic [15:0] fetch_addr_r;
  logic [1:0] osc_freq_sel_r;
  int err_count, samples_checked, i;
  logic [7:0] f_tab [6] = '{8'h01, 8'h10, 8'h20, 8'h40, 8'h04, 8'h02}; // expected flags per cause
  logic [7:0] m_tab [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h02}; // others kept from earlier resets after power-on
  rsw_reset_ctrl #(.POR_CYCLES(40), .MCD_CYCLES(30)) uut (.*);
  rsw_ext_model u_ext (.*);
  always #2.5 pclk = ~pclk;
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h", $time, m, got);
      err_count++;
    end
  endtask
  // one apb transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_r !== 1'b1 && n < 16);
    r = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk(32'h0, 32'h1, "no pready");
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(r, e, "read");
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  // waits for a reset level, notes any pin drive meanwhile
  task wait_lvl(input logic v, input int lim);
    int n;
    n = 0;
    while (sys_rst_n_r !== v && n < lim) begin
      @(posedge pclk);
      n++;
      if (rst_pin_oe_n_r === 1'b0) drove = 1'b1;
    end
    chk(32'(sys_rst_n_r), 32'(v), "reset level");
    chk(32'(fetch_en_r), 32'(v), "fetch enable");
  endtask
  // full reset cycle: enter, drop stimulus, leave, read flags
  task see_reset(input logic [7:0] f, input logic [7:0] m, input logic d);
    drove = 1'b0;
    wait_lvl(1'b0, 2000);
    hold_low <= 1'b0;
    comparator_below <= 1'b0;
    conversion_start_signal_n <= 1'b1;
    clk_run <= 1'b1;
    supply_above_threshold <= 1'b1;
    wait_lvl(1'b1, 2000);
    chk(32'(drove), 32'(d), "pin drive");
    apb(1'b0, OFS_RST_SRC, 8'h00);
    chk(r & 32'(m), 32'(f), "flags");
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #60us;
    err_count++;
    tally_and_finish;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    hold_low = 1'b0; clk_run = 1'b1; supply_monitor_enable_pin = 1'b1; supply_above_threshold = 1'b1;
    comparator_below = 1'b0; conversion_start_signal_n = 1'b1; err_count = 0; samples_checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl(1'b1, 500);
    rd(OFS_RST_SRC, 32'h02);
    rd(OFS_WDOG, 32'h17);
    apb(1'b0, 8'h08, 8'h00);
    chk(32'(er), 32'h1, "unmapped");
    wr(OFS_WDOG, 8'h02);
    rd(OFS_WDOG, 32'h12);
    repeat (900) @(posedge pclk);
    chk(32'(sys_rst_n_r), 32'h1, "watchdog early");
    see_reset(8'h08, 8'hff, 1'b0);
    rd(OFS_WDOG, 32'h17);
    wr(OFS_WDOG, KEY_DIS1);
    repeat (5) @(posedge pclk);
    wr(OFS_WDOG, KEY_DIS2);
    rd(OFS_WDOG, 32'h17);
    wr(OFS_WDOG, KEY_DIS1);
    wr(OFS_WDOG, KEY_DIS2);
    wr(OFS_WDOG, 8'h00);
    rd(OFS_WDOG, 32'h00);
    repeat (100) @(posedge pclk);
    chk(32'(sys_rst_n_r), 32'h1, "disabled watchdog fired");
    wr(OFS_WDOG, KEY_RELOAD);
    rd(OFS_WDOG, 32'h10);
    wr(OFS_WDOG, KEY_LOCK);
    wr(OFS_WDOG, KEY_DIS1);
    wr(OFS_WDOG, KEY_DIS2);
    rd(OFS_WDOG, 32'h10);
    see_reset(8'h08, 8'hff, 1'b0);
    for (i = 0; i < 6; i++) begin
      case (i)
        0: hold_low <= 1'b1;
        1: wr(OFS_RST_SRC, 8'h12);
        2: begin
          wr(OFS_RST_SRC, 8'h22);
          comparator_below <= 1'b1;
        end
        3: begin
          conversion_start_signal_n <= 1'b0;
          repeat (3) @(posedge pclk);
          chk(32'(adc_trigger_r), 32'h1, "conversion trigger");
          conversion_start_signal_n <= 1'b1;
          wr(OFS_RST_SRC, 8'h42);
          conversion_start_signal_n <= 1'b0;
        end
        4: begin
          wr(OFS_RST_SRC, 8'h06);
          clk_run <= 1'b0;
        end
        default: supply_above_threshold <= 1'b0;
      endcase
      see_reset(f_tab[i], m_tab[i], i == 5);
    end
    tally_and_finish;
  end
endmodule // rsw_reset_ctrl_tb
bind rsw_reset_ctrl rsw_checker u_chk (.*);

// file: verilog/rsw_cycle_timer.sv
// down-counting timeout used for reset stretching and missing clock detection
// assumes load and run are synchronous to pclk
`timescale 1ns/1ps
module rsw_cycle_timer #(
  parameter int unsigned W = rsw_pkg::TMR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  output logic expired
);
  import rsw_pkg::*;

  logic [W-1:0] cnt_r; // cycles left
  logic [W-1:0] cnt_nxt; // next count

  // ------------------------------------------------------------
  // count
  // ------------------------------------------------------------
  // load wins, then count down to zero and stay there
  assign cnt_nxt = load ? load_val : (run && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  assign expired = (cnt_r == '0);

  // counter flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // rsw_cycle_timer

// file: verilog/rsw_reset_ctrl.sv
// reset source controller: source gathering, reset sequencing, flags, watchdog and apb slave
// assumes all pins are synchronous to pclk and pclk is the system clock
`timescale 1ns/1ps
//
// Summary of operation
// - port latches load all ones during reset
// - fetch starts at zero after clock stable
// - clock select defaults to internal slowest
// - supply reset drives pin low through timeout
// - power-on flag set on supply resets only
// - pin low resets, hold twelve cycles after
// - pin reset sets the pin flag
// - missing clock resets and flags when enabled
// - writing missing clock bit enables detector
// - comparator below resets when enabled, flags
// - conversion start low resets when enabled, flags
// - conversion start reset blocks conversion triggers
// - internal resets leave the pin undriven
// - 21-bit watchdog overflow forces reset
// - reload key enables and restarts watchdog
// - disable needs two keys within four clocks
// - lock key blocks disable until reset
// - interval field gives four to three-plus-field
// - every reset enables watchdog, interval maximum
// - watchdog control bit four reads active
module rsw_reset_ctrl #(
  parameter int unsigned POR_CYCLES = rsw_pkg::POR_CYCLES,
  parameter int unsigned MCD_CYCLES = rsw_pkg::MCD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsw_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  input wire logic rst_pin_in_n,
  output logic rst_pin_out_r,
  output logic rst_pin_oe_n_r,
  input wire logic supply_monitor_enable_pin,
  input wire logic supply_above_threshold,
  input wire logic comparator_below,
  input wire logic conversion_start_signal_n,
  input wire logic sysclk_tick,
  input wire logic clock_stable,
  output logic sys_rst_n_r,
  output logic port_latch_load_r,
  output logic [7:0] port_latch_r,
  output logic fetch_en_r,
  output logic [15:0] fetch_addr_r,
  output logic clk_src_sel_r,
  output logic [1:0] osc_freq_sel_r,
  output logic adc_trigger_r
);
  import rsw_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  rsw_state_t state_r; // sequencer state
  rsw_state_t state_nxt;
  rsw_cause_t cause_r; // cause of the reset in progress
  rsw_cause_t cause_nxt;
  logic [NUM_FLAGS-1:0] flags_r; // last reset cause flags
  logic cnv_en_r; // conversion start is a reset source
  logic cmp_en_r; // comparator is a reset source
  logic mcd_en_r; // missing clock detector enabled
  logic por_sel_r; // supply monitor selected as source
  logic force_por_r; // pulse: software forced power-on reset
  logic force_sw_r; // pulse: software reset
  logic tick_q_r; // last sysclk_tick level
  logic wd_active; // watchdog running
  logic [2:0] wd_interval; // watchdog interval field
  logic wd_expire; // pulse: watchdog overflow
  logic stretch_exp; // reset stretch timer at zero
  logic mcd_exp; // missing clock timer at zero

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire running = (state_r == ST_RUN);
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_r & pwrite;
  wire sel_src = (paddr == OFS_RST_SRC);
  wire sel_wd = (paddr == OFS_WDOG);
  wire addr_ok = sel_src | sel_wd;
  wire wr_src = apb_wr & sel_src & running;
  wire wr_wd = apb_wr & sel_wd & running;

  // read views of the two registers
  wire [7:0] src_rd = {1'b0, flags_r};
  wire [7:0] wd_rd = {3'h0, wd_active, 1'b0, wd_interval};
  wire [7:0] rd_mux = sel_src ? src_rd : sel_wd ? wd_rd : 8'h00;

  // ------------------------------------------------------------
  // reset sources
  // ------------------------------------------------------------
  wire pin_drive = ~rst_pin_oe_n_r;
  wire sys_edge = sysclk_tick ^ tick_q_r;
  wire por_src = (supply_monitor_enable_pin & por_sel_r & ~supply_above_threshold) | force_por_r;
  wire pin_src = ~rst_pin_in_n & ~pin_drive;
  wire mcd_src = mcd_en_r & mcd_exp;
  wire cmp_src = cmp_en_r & comparator_below;
  wire cnv_src = cnv_en_r & ~conversion_start_signal_n;
  wire wdt_src = wd_expire & running;
  wire any_src = por_src | pin_src | mcd_src | cmp_src | cnv_src | wdt_src | force_sw_r;
  wire held_src = por_src | pin_src;

  // priority of simultaneous causes at entry
  wire rsw_cause_t cause_pick = rsw_cause_t'(por_src ? CAUSE_POR : pin_src ? CAUSE_PIN :
    wdt_src ? CAUSE_WDT : mcd_src ? CAUSE_MCD : cmp_src ? CAUSE_CMP :
    cnv_src ? CAUSE_CNV : CAUSE_SW);
  // a held source arriving during reset takes over the cause
  wire rsw_cause_t cause_hold = rsw_cause_t'(por_src ? CAUSE_POR : pin_src ? CAUSE_PIN : cause_r);

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  // enter on any source, hold while por or pin asserted, stretch, then wait clock
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    case (state_r)
      ST_RUN: begin
        if (any_src) begin
          state_nxt = ST_ACTIVE;
          cause_nxt = cause_pick;
        end
      end
      ST_ACTIVE: begin
        cause_nxt = cause_hold;
        if (!held_src) begin
          state_nxt = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        cause_nxt = cause_hold;
        if (held_src) begin
          state_nxt = ST_ACTIVE;
        end else if (stretch_exp) begin
          state_nxt = ST_WAIT_CLK;
        end
      end
      ST_WAIT_CLK: begin
        cause_nxt = cause_hold;
        if (held_src) begin
          state_nxt = ST_ACTIVE;
        end else if (clock_stable) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_ACTIVE;
        cause_nxt = CAUSE_POR;
      end
    endcase
  end

  // ------------------------------------------------------------
  // register next values
  // ------------------------------------------------------------
  wire leaving = (state_r == ST_WAIT_CLK) & (state_nxt == ST_RUN);
  wire in_rst_nxt = (state_nxt != ST_RUN);
  // supply resets keep the other flags; any other reset shows only its own flag
  wire [NUM_FLAGS-1:0] exit_flags = (cause_r == CAUSE_POR) ?
    (flags_r | cause_flag(CAUSE_POR)) : cause_flag(cause_r);
  wire [NUM_FLAGS-1:0] flags_nxt = leaving ? exit_flags : flags_r;
  // enables drop and the supply select sets on every reset; all are written while running
  wire cnv_en_nxt = running & (wr_src ? pwdata[BIT_CNV] : cnv_en_r);
  wire cmp_en_nxt = running & (wr_src ? pwdata[BIT_CMP] : cmp_en_r);
  wire mcd_en_nxt = running & (wr_src ? pwdata[BIT_MCD] : mcd_en_r);
  wire por_sel_nxt = ~running | (wr_src ? pwdata[BIT_POR] : por_sel_r);
  // only supply resets drive the pin; others leave it released
  wire pin_drive_nxt = in_rst_nxt & (cause_nxt == CAUSE_POR);
  wire [TMR_W-1:0] hold_val = (cause_r == CAUSE_POR) ? TMR_W'(POR_CYCLES) : TMR_W'(PIN_HOLD_CYCLES);

  // apb answer next values
  wire [31:0] prdata_nxt = apb_setup ? {24'h000000, rd_mux} : prdata_r;
  wire pslverr_nxt = apb_setup & ~addr_ok;

  // ------------------------------------------------------------
  // timers and watchdog
  // ------------------------------------------------------------
  // reset stretch: loaded until stretching starts
  rsw_cycle_timer #(.W(TMR_W)) u_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .load(state_r != ST_STRETCH),
    .load_val(hold_val),
    .run(1'b1),
    .expired(stretch_exp)
  );

  // missing clock: restarted by every system clock tick
  rsw_cycle_timer #(.W(TMR_W)) u_mcd (
    .pclk(pclk),
    .presetn(presetn),
    .load(~mcd_en_r | sys_edge),
    .load_val(TMR_W'(MCD_CYCLES)),
    .run(1'b1),
    .expired(mcd_exp)
  );

  // watchdog held in its reset state while the device is in reset
  rsw_wdog u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .sys_rst(~running),
    .wr_en(wr_wd),
    .wr_data(pwdata[7:0]),
    .active_r(wd_active),
    .interval_r(wd_interval),
    .expire_r(wd_expire)
  );

  // ------------------------------------------------------------
  // sequencer and flag flops
  // ------------------------------------------------------------
  // power-up is a supply reset in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_ACTIVE;
      cause_r <= CAUSE_POR;
      flags_r <= RST_SRC_RESET[NUM_FLAGS-1:0];
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ------------------------------------------------------------
  // control bit flops
  // ------------------------------------------------------------
  // enables, selects and software force pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnv_en_r <= 1'b0;
      cmp_en_r <= 1'b0;
      mcd_en_r <= 1'b0;
      por_sel_r <= 1'b1;
      force_por_r <= 1'b0;
      force_sw_r <= 1'b0;
      tick_q_r <= 1'b0;
    end else begin
      cnv_en_r <= cnv_en_nxt;
      cmp_en_r <= cmp_en_nxt;
      mcd_en_r <= mcd_en_nxt;
      por_sel_r <= por_sel_nxt;
      force_por_r <= wr_src & pwdata[BIT_PIN];
      force_sw_r <= wr_src & pwdata[BIT_SW];
      tick_q_r <= sysclk_tick;
    end
  end

  // ------------------------------------------------------------
  // apb answer flops
  // ------------------------------------------------------------
  // one setup cycle then a zero-wait access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= apb_setup;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin and system output flops
  // ------------------------------------------------------------
  // pin drive, reset state and exit defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_out_r <= 1'b0;
      rst_pin_oe_n_r <= 1'b0;
      sys_rst_n_r <= 1'b0;
      port_latch_load_r <= 1'b1;
      port_latch_r <= PORT_RESET_VALUE;
      fetch_en_r <= 1'b0;
      fetch_addr_r <= RESET_VECTOR;
      clk_src_sel_r <= CLK_SRC_INTERNAL;
      osc_freq_sel_r <= OSC_FREQ_LOWEST;
      adc_trigger_r <= 1'b0;
    end else begin
      rst_pin_out_r <= 1'b0;
      rst_pin_oe_n_r <= ~pin_drive_nxt;
      sys_rst_n_r <= ~in_rst_nxt;
      port_latch_load_r <= in_rst_nxt;
      port_latch_r <= PORT_RESET_VALUE;
      fetch_en_r <= ~in_rst_nxt;
      fetch_addr_r <= RESET_VECTOR;
      clk_src_sel_r <= CLK_SRC_INTERNAL;
      osc_freq_sel_r <= OSC_FREQ_LOWEST;
      adc_trigger_r <= running & ~cnv_en_r & ~conversion_start_signal_n;
    end
  end

endmodule // rsw_reset_ctrl

// file: verilog/rsw_wdog.sv
// watchdog timer with key-coded control writes
// assumes wr_en is a one-cycle pulse per register write and sys_rst is high while the device is in reset
`timescale 1ns/1ps
module rsw_wdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic active_r,
  output logic [2:0] interval_r,
  output logic expire_r
);
  import rsw_pkg::*;

  logic [WD_CNT_W-1:0] count_r; // elapsed clocks since restart
  logic [2:0] dis_win_r; // clocks left to accept the second key
  logic locked_r; // disable lockout

  // timeout in clocks for an interval code
  function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [2:0] i);
    wd_limit = WD_CNT_W'(1) << (2 * (WD_EXP_BASE + int'(i)));
  endfunction

  // ------------------------------------------------------------
  // key decode
  // ------------------------------------------------------------
  wire k_reload = wr_en & (wr_data == KEY_RELOAD);
  wire k_dis1 = wr_en & (wr_data == KEY_DIS1);
  wire k_dis2 = wr_en & (wr_data == KEY_DIS2);
  wire k_lock = wr_en & (wr_data == KEY_LOCK);
  wire k_int = wr_en & ~wr_data[WD_KEY_BIT];
  wire disable_ok = k_dis2 & (dis_win_r != '0) & ~locked_r;
  wire at_limit = active_r & (count_r == wd_limit(interval_r) - WD_CNT_W'(1));

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  wire active_nxt = sys_rst | k_reload | (active_r & ~disable_ok);
  wire [WD_CNT_W-1:0] count_nxt = (sys_rst | k_reload | at_limit) ? '0 :
    active_r ? count_r + 1'b1 : count_r;
  // any other write between the keys cancels the window
  wire [2:0] dis_win_nxt = sys_rst ? '0 : k_dis1 ? DIS_WINDOW :
    wr_en ? '0 : (dis_win_r != '0) ? dis_win_r - 1'b1 : '0;
  wire locked_nxt = ~sys_rst & (locked_r | k_lock);
  wire [2:0] interval_nxt = sys_rst ? WD_INT_RESET : k_int ? wr_data[2:0] : interval_r;

  // watchdog state flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b1;
      count_r <= '0;
      dis_win_r <= '0;
      locked_r <= 1'b0;
      interval_r <= WD_INT_RESET;
      expire_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      count_r <= count_nxt;
      dis_win_r <= dis_win_nxt;
      locked_r <= locked_nxt;
      interval_r <= interval_nxt;
      expire_r <= at_limit & ~sys_rst;
    end
  end

endmodule // rsw_wdog
